// ### src/cawt_area_timer.sv
// access timer for one chip-select area of the external memory bus
//
// Operation
// R01: read waits per 4-bit code: 0-6 linear, then 8,10,12,14,18,24 cycles.
// R02: software must never program read wait codes 1101, 1110 or 1111.
// R03: read wait code resets to 1010, fourteen wait cycles.
// R04: mask bit 0 honours external wait, 1 ignores it; resets to 0.
// R05: mask setting applies even with zero programmed wait cycles.
// R06: bits 5 to 2 always read 0; software writes 0 there.
// R07: select and address hold after strobe: 0.5, 1.5, 2.5, 3.5 cycles; the code holds select 1, 2, 3 or 4 whole cycles.
// R08: hold field resets to 00, the half-cycle hold; in the code 00 gives a one-cycle hold.
// R09: write wait code 000 makes writes use the read wait count.
// R10: programmed waits elapse first, then unmasked external wait stretches.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cawt_cfg.svh"

module cawt_area_timer
	import cawt_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
)
(
	// clock and reset
	input  wire logic                 ref_clk_in,
	input  wire logic                 resetn_in,
	// register port
	input  wire logic [`CAWT_AW-1:0]  reg_addr_in,
	input  wire logic [31:0]          reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output      logic [31:0]          reg_rdata_out,
	// internal access request
	input  wire logic                 acc_req_in,
	input  wire logic                 acc_write_in,
	input  wire logic [ADDR_W-1:0]    acc_addr_in,
	input  wire logic [DATA_W-1:0]    acc_wdata_in,
	output      logic                 acc_ready_out,
	output      logic                 acc_done_out,
	output      logic [DATA_W-1:0]    acc_rdata_out,
	// external memory pins
	output      logic [ADDR_W-1:0]    mem_addr_out,
	output      logic                 area_select_n_out,
	output      logic                 read_strobe_n_out,
	output      logic                 byte_lane_strobe_n_out,
	output      logic [DATA_W-1:0]    mem_data_out,
	output      logic                 mem_data_oe_n_out,
	input  wire logic [DATA_W-1:0]    mem_data_in,
	input  wire logic                 ext_wait_in
);
	if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 32)
	begin : g_bad_width
		$error("cawt_area_timer: widths must be 1 to 32");
	end

	//--------------------------------------------------------------------
	// configuration register
	//--------------------------------------------------------------------
	logic [3:0] read_wait_count_r;
	logic [3:0] read_wait_count_nxt;
	logic       ext_wait_mask_r;
	logic       ext_wait_mask_nxt;
	logic [1:0] strobe_hold_delay_r;
	logic [1:0] strobe_hold_delay_nxt;
	logic [2:0] write_wait_count_r;
	logic [2:0] write_wait_count_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        cfg_written_r;
	logic        cfg_written_nxt;
	logic        wr_cfg;

	cawt_state_t state_r;
	cawt_state_t state_nxt;

	assign wr_cfg = reg_wr_in && (reg_addr_in == `CAWT_OFF_WAITCFG);

	always_comb
	begin
		read_wait_count_nxt   = read_wait_count_r;
		ext_wait_mask_nxt     = ext_wait_mask_r;
		strobe_hold_delay_nxt = strobe_hold_delay_r;
		write_wait_count_nxt  = write_wait_count_r;
		cfg_written_nxt       = cfg_written_r;
		rdata_nxt             = 32'h0000_0000;
		if (wr_cfg)
		begin
			read_wait_count_nxt   = reg_wdata_in[`CAWT_RW_HI:`CAWT_RW_LO];
			ext_wait_mask_nxt     = reg_wdata_in[`CAWT_MASK_BIT];
			strobe_hold_delay_nxt = reg_wdata_in[`CAWT_HOLD_HI:`CAWT_HOLD_LO];
			write_wait_count_nxt  = reg_wdata_in[`CAWT_WW_HI:`CAWT_WW_LO];
			cfg_written_nxt       = 1'b1;
		end
		if (reg_rd_in)
		begin
			if (reg_addr_in == `CAWT_OFF_WAITCFG)
			begin
				// bits 5 to 2 are never stored and read as zero
				rdata_nxt[`CAWT_WW_HI:`CAWT_WW_LO]     = write_wait_count_r;
				rdata_nxt[`CAWT_RW_HI:`CAWT_RW_LO]     = read_wait_count_r;
				rdata_nxt[`CAWT_MASK_BIT]              = ext_wait_mask_r; // R06
				rdata_nxt[`CAWT_HOLD_HI:`CAWT_HOLD_LO] = strobe_hold_delay_r;
			end
			else if (reg_addr_in == `CAWT_OFF_STATUS)
			begin
				rdata_nxt[4:0] = state_r;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			read_wait_count_r   <= `CAWT_RW_RST; // R03
			ext_wait_mask_r     <= `CAWT_MASK_RST; // R04
			strobe_hold_delay_r <= `CAWT_HOLD_RST; // R08
			write_wait_count_r  <= `CAWT_WW_RST;
			cfg_written_r       <= 1'b0;
			rdata_r             <= 32'h0000_0000;
		end
		else
		begin
			read_wait_count_r   <= read_wait_count_nxt;
			ext_wait_mask_r     <= ext_wait_mask_nxt;
			strobe_hold_delay_r <= strobe_hold_delay_nxt;
			write_wait_count_r  <= write_wait_count_nxt;
			cfg_written_r       <= cfg_written_nxt;
			rdata_r             <= rdata_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;

	//--------------------------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------------------------
	logic              wait_meta_r;
	logic              wait_sync_r;
	logic [DATA_W-1:0] data_meta_r;
	logic [DATA_W-1:0] data_sync_r;

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wait_meta_r <= 1'b0;
			wait_sync_r <= 1'b0;
			data_meta_r <= '0;
			data_sync_r <= '0;
		end
		else
		begin
			wait_meta_r <= ext_wait_in;
			wait_sync_r <= wait_meta_r;
			data_meta_r <= mem_data_in;
			data_sync_r <= data_meta_r;
		end
	end

	//--------------------------------------------------------------------
	// access sequencer
	//--------------------------------------------------------------------
	cawt_ctr_if cif ();

	cawt_wait_ctr u_ctr (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.cif        (cif.ctr)
	);

	cawt_cnt_t         wait_cycles;
	logic              ext_stall;
	logic              is_write_r;
	logic              is_write_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] wdata_nxt;
	logic [DATA_W-1:0] acc_rdata_r;
	logic [DATA_W-1:0] acc_rdata_nxt;
	logic              sel_n_r;
	logic              sel_n_nxt;
	logic              rd_n_r;
	logic              rd_n_nxt;
	logic              wr_n_r;
	logic              wr_n_nxt;
	logic              done_r;
	logic              done_nxt;
	logic              ready_r;
	logic              ready_nxt;
	logic              oe_n_r;
	logic              oe_n_nxt;

	always_comb
	begin
		wait_cycles = cawt_decode_wait(read_wait_count_r); // R01
		if (acc_write_in && write_wait_count_r != `CAWT_WW_SAME)
			wait_cycles = cawt_cnt_t'(write_wait_count_r - 3'h1);
	end

	// external wait only counts while unmasked
	assign ext_stall = wait_sync_r && !ext_wait_mask_r; // R04

	always_comb
	begin
		state_nxt     = state_r;
		is_write_nxt  = is_write_r;
		addr_nxt      = addr_r;
		wdata_nxt     = wdata_r;
		acc_rdata_nxt = acc_rdata_r;
		sel_n_nxt     = sel_n_r;
		rd_n_nxt      = rd_n_r;
		wr_n_nxt      = wr_n_r;
		done_nxt      = 1'b0;
		ready_nxt     = ready_r;
		cif.load      = 1'b0;
		cif.load_val  = `CAWT_ZERO_CNT;
		case (state_r)
			CAWT_IDLE:
			begin
				if (acc_req_in)
				begin
					state_nxt    = CAWT_STROBE;
					is_write_nxt = acc_write_in;
					addr_nxt     = acc_addr_in;
					wdata_nxt    = acc_wdata_in;
					sel_n_nxt    = 1'b0;
					rd_n_nxt     = acc_write_in;
					wr_n_nxt     = !acc_write_in;
					ready_nxt    = 1'b0;
					cif.load     = 1'b1;
					cif.load_val = wait_cycles; // R09
				end
			end
			CAWT_STROBE:
			begin
				// count first, then the unmasked external wait
				if (cif.zero && !ext_stall) // R05 R10
				begin
					state_nxt    = CAWT_HOLD;
					rd_n_nxt     = 1'b1;
					wr_n_nxt     = 1'b1;
					if (!is_write_r)
						acc_rdata_nxt = data_sync_r;
					cif.load     = 1'b1;
					cif.load_val = cawt_cnt_t'(strobe_hold_delay_r); // R07
				end
			end
			CAWT_HOLD:
			begin
				if (cif.zero)
				begin
					state_nxt = CAWT_END;
					sel_n_nxt = 1'b1;
					done_nxt  = 1'b1;
				end
			end
			CAWT_END:
			begin
				state_nxt = CAWT_IDLE;
				ready_nxt = 1'b1;
			end
			default:
			begin
				state_nxt = CAWT_IDLE;
				sel_n_nxt = 1'b1;
				rd_n_nxt  = 1'b1;
				wr_n_nxt  = 1'b1;
				ready_nxt = 1'b1;
			end
		endcase
		// data bus driven only while a write holds the area selected
		oe_n_nxt = sel_n_nxt || !is_write_nxt;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r     <= CAWT_IDLE;
			is_write_r  <= 1'b0;
			addr_r      <= '0;
			wdata_r     <= '0;
			acc_rdata_r <= '0;
			sel_n_r     <= 1'b1;
			rd_n_r      <= 1'b1;
			wr_n_r      <= 1'b1;
			done_r      <= 1'b0;
			ready_r     <= 1'b1;
			oe_n_r      <= 1'b1;
		end
		else
		begin
			state_r     <= state_nxt;
			is_write_r  <= is_write_nxt;
			addr_r      <= addr_nxt;
			wdata_r     <= wdata_nxt;
			acc_rdata_r <= acc_rdata_nxt;
			sel_n_r     <= sel_n_nxt;
			rd_n_r      <= rd_n_nxt;
			wr_n_r      <= wr_n_nxt;
			done_r      <= done_nxt;
			ready_r     <= ready_nxt;
			oe_n_r      <= oe_n_nxt;
		end
	end

	assign mem_addr_out           = addr_r;
	assign area_select_n_out      = sel_n_r;
	assign read_strobe_n_out      = rd_n_r;
	assign byte_lane_strobe_n_out = wr_n_r;
	assign mem_data_out           = wdata_r;
	assign mem_data_oe_n_out      = oe_n_r;
	assign acc_ready_out          = ready_r;
	assign acc_done_out           = done_r;
	assign acc_rdata_out          = acc_rdata_r;

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	a_reset_wait_code: assert property (@(posedge ref_clk_in) // R03
		disable iff (!resetn_in)
		!cfg_written_r |-> (read_wait_count_r == `CAWT_RW_RST &&
		strobe_hold_delay_r == `CAWT_HOLD_RST && !ext_wait_mask_r))
		else $error("configuration lost its reset value");

	a_rsvd_read_zero: assert property (@(posedge ref_clk_in) // R06
		disable iff (!resetn_in)
		reg_rdata_out[5:2] == 4'h0)
		else $error("reserved bits read nonzero");

	a_read_wait_len: assert property (@(posedge ref_clk_in) // R01
		disable iff (!resetn_in)
		(state_r == CAWT_IDLE && acc_req_in && !acc_write_in &&
		read_wait_count_r == `CAWT_RW_RST) |->
		(cif.load && cif.load_val == `CAWT_WAIT_A))
		else $error("read wait not loaded from code");

	a_mask_ignores: assert property (@(posedge ref_clk_in) // R04
		disable iff (!resetn_in)
		(state_r == CAWT_STROBE && cif.zero && ext_wait_mask_r) |=>
		(state_r == CAWT_HOLD && read_strobe_n_out &&
		byte_lane_strobe_n_out))
		else $error("masked wait still stretched the strobe");

	a_wait_stretches: assert property (@(posedge ref_clk_in) // R05
		disable iff (!resetn_in)
		(state_r == CAWT_STROBE && cif.zero && wait_sync_r &&
		!ext_wait_mask_r) |=> (state_r == CAWT_STROBE))
		else $error("unmasked wait failed to stretch");

	a_count_first: assert property (@(posedge ref_clk_in) // R10
		disable iff (!resetn_in)
		(state_r == CAWT_STROBE && !cif.zero) |=> state_r == CAWT_STROBE)
		else $error("strobe ended before wait count");

	a_hold_time: assert property (@(posedge ref_clk_in) // R07
		disable iff (!resetn_in)
		(state_r == CAWT_STROBE && $past(state_r) == CAWT_STROBE &&
		strobe_hold_delay_r == 2'h0 && cif.zero && !ext_stall) |=>
		!area_select_n_out ##1 area_select_n_out)
		else $error("select hold after strobe is wrong");

	a_write_same_wait: assert property (@(posedge ref_clk_in) // R09
		disable iff (!resetn_in)
		(state_r == CAWT_IDLE && acc_req_in && acc_write_in &&
		write_wait_count_r == `CAWT_WW_SAME) |->
		cif.load_val == cawt_decode_wait(read_wait_count_r))
		else $error("write wait ignored the read wait code");

	a_select_covers: assert property (@(posedge ref_clk_in) // R07
		disable iff (!resetn_in)
		(!read_strobe_n_out || !byte_lane_strobe_n_out) |->
		!area_select_n_out)
		else $error("strobe active without area select");
endmodule : cawt_area_timer

// ### src/cawt_cfg.svh
// offsets, field positions, reset values and timing counts of the area timer
`ifndef CAWT_CFG_SVH
`define CAWT_CFG_SVH

`define CAWT_AW            8
`define CAWT_OFF_WAITCFG   8'h00
`define CAWT_OFF_STATUS    8'h04

`define CAWT_RW_HI         10
`define CAWT_RW_LO         7
`define CAWT_MASK_BIT      6
`define CAWT_HOLD_HI       1
`define CAWT_HOLD_LO       0
`define CAWT_WW_HI         18
`define CAWT_WW_LO         16

`define CAWT_RW_RST        4'h a
`define CAWT_MASK_RST      1'h0
`define CAWT_HOLD_RST      2'h0
`define CAWT_WW_RST        3'h0
`define CAWT_WW_SAME       3'h0

`define CAWT_CW            5
`define CAWT_LIN_MAX       4'h6
`define CAWT_WAIT_7        5'h08
`define CAWT_WAIT_8        5'h0a
`define CAWT_WAIT_9        5'h0c
`define CAWT_WAIT_A        5'h0e
`define CAWT_WAIT_B        5'h12
`define CAWT_WAIT_C        5'h18
`define CAWT_ZERO_CNT      5'h00

`endif

// ### src/cawt_pkg.sv
// types and the wait-code decoder shared by the area timer modules
`include "cawt_cfg.svh"

package cawt_pkg;

	typedef enum logic [4:0] {
		CAWT_IDLE   = 5'b0_0001,
		CAWT_STROBE = 5'b0_0010,
		CAWT_HOLD   = 5'b0_0100,
		CAWT_END    = 5'b0_1000,
		CAWT_SPARE  = 5'b1_0000
	} cawt_state_t;

	typedef logic [`CAWT_CW-1:0] cawt_cnt_t;

	// read wait code to cycle count; prohibited codes give zero
	function automatic cawt_cnt_t cawt_decode_wait(input logic [3:0] code);
		cawt_cnt_t val;
		val = `CAWT_ZERO_CNT;
		if (code <= `CAWT_LIN_MAX)
			val = cawt_cnt_t'(code);
		else if (code == 4'h7)
			val = `CAWT_WAIT_7;
		else if (code == 4'h8)
			val = `CAWT_WAIT_8;
		else if (code == 4'h9)
			val = `CAWT_WAIT_9;
		else if (code == 4'ha)
			val = `CAWT_WAIT_A;
		else if (code == 4'hb)
			val = `CAWT_WAIT_B;
		else if (code == 4'hc)
			val = `CAWT_WAIT_C;
		return val;
	endfunction : cawt_decode_wait

endpackage : cawt_pkg

// ### src/cawt_ctr_if.sv
// load and status link between the access sequencer and its cycle counter
`timescale 1ns/1ps

interface cawt_ctr_if;
	import cawt_pkg::*;
	logic       load;
	cawt_cnt_t  load_val;
	logic       zero;

	modport seq (output load, output load_val, input zero);
	modport ctr (input load, input load_val, output zero);
endinterface : cawt_ctr_if

// ### src/cawt_wait_ctr.sv
// down counter that times the strobe and hold phases
`timescale 1ns/1ps

module cawt_wait_ctr
	import cawt_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk_in,
	input  wire logic resetn_in,
	// sequencer link
	cawt_ctr_if.ctr   cif
);
	cawt_cnt_t count_r;
	cawt_cnt_t count_nxt;

	always_comb
	begin
		count_nxt = count_r;
		if (cif.load)
			count_nxt = cif.load_val;
		else if (count_r != `CAWT_ZERO_CNT)
			count_nxt = count_r - cawt_cnt_t'(1);
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			count_r <= `CAWT_ZERO_CNT;
		else
			count_r <= count_nxt;
	end

	assign cif.zero = (count_r == `CAWT_ZERO_CNT);

	a_ctr_counts_down: assert property (@(posedge ref_clk_in)
		disable iff (!resetn_in)
		(!cif.load && count_r != `CAWT_ZERO_CNT) |=>
		count_r == $past(count_r) - cawt_cnt_t'(1))
		else $error("wait counter did not count down");
endmodule : cawt_wait_ctr

// ### sim/cawt_mem_model.sv
// behavioural sram-like memory with a commandable wait line
`timescale 1ns/1ps

module cawt_mem_model #(
	parameter int AW = 24,
	parameter int DW = 16
)
(
	// clock
	input  wire logic          clk_in,
	// memory pins
	input  wire logic          select_n_in,
	input  wire logic          rd_n_in,
	input  wire logic          wr_n_in,
	input  wire logic          oe_n_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [DW-1:0] data_in,
	output      logic [DW-1:0] data_out,
	output      logic          wait_out,
	// wait command from the bench
	input  wire logic          wait_arm_in,
	input  wire logic [7:0]    wait_len_in
);
	logic [DW-1:0] mem [16];
	logic [DW-1:0] junk = '0;
	logic [7:0]    wait_cnt = 8'h00;

	// released bus shows a pattern that changes every cycle
	always @(posedge clk_in)
	begin
		junk <= ~junk;
		if (!select_n_in && !wr_n_in && !oe_n_in)
			mem[addr_in[3:0]] <= data_in;
		if (wait_arm_in)
			wait_cnt <= wait_len_in;
		else if (wait_cnt != 8'h00)
			wait_cnt <= wait_cnt - 8'h01;
	end

	assign data_out = (!select_n_in && !rd_n_in) ? mem[addr_in[3:0]] : junk;
	assign wait_out = (wait_cnt != 8'h00);
endmodule : cawt_mem_model

// ### sim/cawt_area_timer_tb.sv
// self-checking bench for the area access timer
`timescale 1ns/1ps

module cawt_area_timer_tb;
	import cawt_pkg::*;
	logic        ref_clk_in = 1'h0;
	logic        resetn_in = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic        acc_req = 1'h0;
	logic        acc_write = 1'h0;
	logic [23:0] acc_addr = 24'h00_0000;
	logic [15:0] acc_wdata = 16'h0000;
	logic        acc_ready;
	logic        acc_done;
	logic [15:0] acc_rdata;
	logic [23:0] mem_addr;
	logic        sel_n;
	logic        rd_n;
	logic        wr_n;
	logic [15:0] mem_dout;
	logic        oe_n;
	logic [15:0] mem_din;
	logic        ext_wait;
	logic        wait_arm = 1'h0;
	logic [7:0]  wait_len = 8'h00;
	int          errors = 0;
	int          checks = 0;
	int          cycles = 0;

	always #5 ref_clk_in = ~ref_clk_in;

	cawt_area_timer i_dut (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.acc_req_in(acc_req), .acc_write_in(acc_write),
		.acc_addr_in(acc_addr), .acc_wdata_in(acc_wdata),
		.acc_ready_out(acc_ready), .acc_done_out(acc_done),
		.acc_rdata_out(acc_rdata), .mem_addr_out(mem_addr),
		.area_select_n_out(sel_n), .read_strobe_n_out(rd_n),
		.byte_lane_strobe_n_out(wr_n), .mem_data_out(mem_dout),
		.mem_data_oe_n_out(oe_n), .mem_data_in(mem_din),
		.ext_wait_in(ext_wait)
	);

	cawt_mem_model i_mem (
		.clk_in(ref_clk_in), .select_n_in(sel_n), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .oe_n_in(oe_n), .addr_in(mem_addr),
		.data_in(mem_dout), .data_out(mem_din), .wait_out(ext_wait),
		.wait_arm_in(wait_arm), .wait_len_in(wait_len)
	);

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// strobe length must exceed a floor
	task automatic cmp_above(input int got, input int floor);
		checks++;
		if (!(got > floor))
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, floor + 1);
		end
	endtask : cmp_above

	function automatic logic [31:0] cfg(input logic [2:0] ww,
		input logic [3:0] code, input logic m, input logic [1:0] h);
		return {13'h0000, ww, 5'h00, code, m, 4'h0, h};
	endfunction : cfg

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk_in);
		reg_wr <= 1'h0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk_in);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	// one access; counts strobe-low cycles and select-only cycles
	task automatic access(input logic w, input logic [23:0] a,
		input logic [15:0] d, output int str, output int hold,
		output logic [15:0] rd);
		int n;
		str = 0;
		hold = 0;
		@(posedge ref_clk_in);
		acc_req <= 1'h1;
		acc_write <= w;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge ref_clk_in);
		acc_req <= 1'h0;
		#1;
		cmp(mem_addr, a);
		cmp(oe_n, !w);
		cmp(acc_ready, 1'h0);
		for (n = 0; n < 300; n++)
		begin
			#1;
			if (acc_done === 1'h1)
				break;
			if (rd_n === 1'h0 || wr_n === 1'h0)
				str++;
			else if (sel_n === 1'h0)
				hold++;
			@(posedge ref_clk_in);
		end
		rd = acc_rdata;
		cmp(acc_done, 1'h1);
		cmp(sel_n, 1'h1);
		@(posedge ref_clk_in);
		#1;
		cmp(acc_ready, 1'h1);
	endtask : access

	task automatic arm_wait(input logic [7:0] len);
		@(posedge ref_clk_in);
		wait_len <= len;
		wait_arm <= 1'h1;
		@(posedge ref_clk_in);
		wait_arm <= 1'h0;
	endtask : arm_wait

	task automatic t_reset;
		logic [31:0] v;
		logic [15:0] d;
		int s;
		int h;
		reg_read(8'h00, v);
		cmp(v, 32'h0000_0500);
		access(1'h0, 24'h00_0001, 16'h0000, s, h, d);
		cmp(s, 32'h0000_000f);
		cmp(h, 32'h0000_0001);
		$display("done t_reset");
	endtask : t_reset

	task automatic t_fields;
		logic [31:0] v;
		reg_write(8'h00, 32'h0000_067c);
		reg_read(8'h00, v);
		cmp(v, 32'h0000_0640);
		@(posedge ref_clk_in);
		#1;
		cmp(reg_rdata, 32'h0000_0000);
		reg_read(8'h04, v);
		cmp(v, 32'h0000_0001);
		reg_read(8'h08, v);
		cmp(v, 32'h0000_0000);
		$display("done t_fields");
	endtask : t_fields

	task automatic t_codes;
		int waits[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
		logic [15:0] d;
		int s;
		int h;
		// codes 1101 to 1111 are never programmed
		for (int c = 0; c < 13; c++)
		begin
			reg_write(8'h00, cfg(3'h0, c[3:0], 1'h1, 2'h0));
			access(1'h0, 24'h00_0002, 16'h0000, s, h, d);
			cmp(s, 1 + waits[c]);
		end
		$display("done t_codes");
	endtask : t_codes

	task automatic t_hold;
		logic [15:0] d;
		int s;
		int h;
		for (int k = 0; k < 4; k++)
		begin
			reg_write(8'h00, cfg(3'h0, 4'h0, 1'h1, k[1:0]));
			access(1'h1, 24'h00_0003, 16'h1234, s, h, d);
			cmp(h, k + 1);
		end
		$display("done t_hold");
	endtask : t_hold

	task automatic t_write;
		logic [15:0] d;
		int s;
		int h;
		reg_write(8'h00, cfg(3'h0, 4'h3, 1'h1, 2'h0));
		access(1'h1, 24'h00_0005, 16'ha5c3, s, h, d);
		cmp(s, 32'h0000_0004);
		access(1'h0, 24'h00_0005, 16'h0000, s, h, d);
		cmp(d, 16'ha5c3);
		reg_write(8'h00, cfg(3'h1, 4'h3, 1'h1, 2'h0));
		access(1'h1, 24'h00_0006, 16'h0f0f, s, h, d);
		cmp(s, 32'h0000_0001);
		$display("done t_write");
	endtask : t_write

	task automatic t_wait;
		logic [15:0] d;
		int s;
		int h;
		reg_write(8'h00, cfg(3'h0, 4'h0, 1'h0, 2'h0));
		arm_wait(8'h06);
		access(1'h0, 24'h00_0007, 16'h0000, s, h, d);
		cmp_above(s, 1);
		reg_write(8'h00, cfg(3'h0, 4'h0, 1'h1, 2'h0));
		arm_wait(8'h06);
		access(1'h0, 24'h00_0007, 16'h0000, s, h, d);
		cmp(s, 32'h0000_0001);
		reg_write(8'h00, cfg(3'h0, 4'h2, 1'h0, 2'h1));
		arm_wait(8'h0a);
		access(1'h0, 24'h00_0007, 16'h0000, s, h, d);
		cmp_above(s, 3);
		cmp(h, 32'h0000_0002);
		$display("done t_wait");
	endtask : t_wait

	// reset in mid-run brings the configuration back to its reset value
	task automatic t_rearm;
		logic [31:0] v;
		reg_write(8'h00, cfg(3'h2, 4'h1, 1'h1, 2'h3));
		@(posedge ref_clk_in);
		resetn_in <= 1'h0;
		@(posedge ref_clk_in);
		resetn_in <= 1'h1;
		reg_read(8'h00, v);
		cmp(v, 32'h0000_0500);
		$display("done t_rearm");
	endtask : t_rearm

	// hang guard
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (8) @(posedge ref_clk_in);
		resetn_in <= 1'h1;
		t_reset();
		t_fields();
		t_codes();
		t_hold();
		t_write();
		t_wait();
		t_rearm();
		wrap_up();
	end
endmodule : cawt_area_timer_tb
